/* logic/sctc_trap_ctrl.sv */
// sctc_trap_ctrl.sv: security config trap controls with a wishbone slave
// assumes a classic wishbone master on i_mclk and one asynchronous reset
//
// Overview of operation
// RL1: txmem off makes transaction instructions undefined
// RL2: delay exponent held; delay is 2^(exp+8)
// RL3: delay enable stretches wfe trap; class 0x01
// RL4: offset enable off traps el2, reads zero
// RL5: fine enable off traps el2, class 0x18
// RL6: tag enable off blocks tags, traps el1/el2
// RL7: context enable off traps, values read zero
// RL8: fault inject enable off traps, class 0x18
// RL9: no top level means fault inject enabled
// RL10: fault inject bit may be reserved zero
// RL11: routed serror nonmaskable ignores abort mask
// RL12: unrouted serror never taken, nonmaskable zero
// RL13: reset clears nonmaskable and sync-abort vector bits
// RL14: sync abort vector selects serror or sync offset
// RL15: secure hyp off makes its registers undefined
// RL16: secure hyp, secure world: lower state aarch64
// RL17: aarch32 monitor config accesses trap, class 0x3
// RL18: aarch32 monitor bank accesses trap, class 0x0
// RL19: other fields reset to unknown values
// RL20: virtual offset enable on leaves accesses alone
// RL21: wfe trap enable traps lower wfe, class 0x01
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sctc_cfg.svh"
module sctc_trap_ctrl
  import sctc_pkg::*;
#(
  parameter bit HAS_TOP_LEVEL = 1'b1,   // top level implemented
  parameter bit HAS_ERR_RECORDS = 1'b1  // fault injection records present
)(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // live decode outputs
  output logic o_lower_state_a64,
  output logic o_sechyp_timers_en,
  output logic o_phys_offset_zero,
  output logic o_ctxnum_zero,
  output logic o_tag_access_ok,
  output logic o_fine_traps_live
);
  ////////////////////////////////////////////////////////////////////////////
  // registered state
  logic [63:0] cfg;        // security config bits held here
  logic [63:0] next_cfg;
  logic [10:0] req;        // last check request
  logic [10:0] next_req;
  logic [1:0] verdict;     // last verdict
  logic [1:0] next_verdict;
  logic [5:0] ec;          // last exception class
  logic [5:0] next_ec;
  logic serr_vec;          // sync abort used serror vector
  logic next_serr_vec;
  logic ack;
  logic next_ack;
  logic [31:0] rdat;
  logic [31:0] next_rdat;
  sctc_state_e state;
  sctc_state_e next_state;
  logic [23:0] dly_cnt;    // wfe delay countdown
  logic [23:0] next_dly_cnt;
  logic busy;              // check in flight

  // effective fault inject enable
  logic fi_eff;
  // effective nonmaskable bit
  logic nm_eff;
  // delay length in cycles
  logic [23:0] dly_len;

  ////////////////////////////////////////////////////////////////////////////
  // effective values
  always_comb
  begin
    // RL9: forced on without top level
    // RL10: reserved zero without error records
    if (!HAS_TOP_LEVEL)
      fi_eff = 1'b1;
    else if (!HAS_ERR_RECORDS)
      fi_eff = 1'b0;
    else
      fi_eff = cfg[`SCTC_B_FAULTINJ];
    // RL12: nonmaskable is zero unless routed
    nm_eff = cfg[`SCTC_B_NMSERR] & cfg[`SCTC_B_EXT_ROUTE];
    // RL2: delay is two to the exponent plus bias
    dly_len = 24'(1) << (5'(cfg[`SCTC_B_DLY_HI:`SCTC_B_DLY_LO]) + `SCTC_DLY_BIAS);
  end

  // writable bits as a vector, so each byte lane can take its own slice
  localparam logic [63:0] CFG_MASK = `SCTC_CFG_MASK;
  ////////////////////////////////////////////////////////////////////////////
  // verdict function for one access
  function automatic logic [7:0] judge(input logic [10:0] r, input logic [63:0] c,
                                       input logic fi, input logic nm);
    logic [3:0] k;
    logic [1:0] el;
    logic [1:0] v;
    logic [5:0] e;
    logic sys_trap;  // system register access traps to the top level
    k = r[`SCTC_RQ_KIND_HI:`SCTC_RQ_KIND_LO];
    el = r[`SCTC_RQ_EL_HI:`SCTC_RQ_EL_LO];
    v = SCTC_V_ALLOW;
    e = `SCTC_EC_NONE;
    sys_trap = 1'b0;
    case (k)
      SCTC_K_TXMEM:
      begin
        // RL1: undefined below top when disabled
        if (el != 2'd3 && !c[`SCTC_B_TXMEM])
          v = SCTC_V_UNDEF;
      end
      SCTC_K_WFE:
      begin
        // RL21: wfe below top traps when enabled
        if (el != 2'd3 && c[`SCTC_B_WFE_TRAP])
        begin
          v = SCTC_V_TRAP_TOP;
          e = `SCTC_EC_WFE;
        end
      end
      SCTC_K_PHYSOFF:
        // RL4: el2 access traps when disabled
        sys_trap = el == 2'd2 && !c[`SCTC_B_PHYSOFF];
      SCTC_K_FINE:
        // RL5: el2 access traps, class 0x18
        sys_trap = el == 2'd2 && !c[`SCTC_B_FINE];
      SCTC_K_TAG:
        // RL6: el1/el2 trap unless caught lower
        sys_trap = (el == 2'd1 || el == 2'd2) && !c[`SCTC_B_TAG] && !r[`SCTC_RQ_LOWER];
      SCTC_K_CTXNUM:
        // RL7: trap below top unless higher priority
        sys_trap = el != 2'd3 && !c[`SCTC_B_CTXNUM] && !r[`SCTC_RQ_LOWER];
      SCTC_K_FAULTINJ:
        // RL8: el1/el2 trap when disabled
        sys_trap = (el == 2'd1 || el == 2'd2) && !fi;
      SCTC_K_SECHYP_REG:
      begin
        // RL15: secure hyp registers undefined when off
        if (!c[`SCTC_B_SECHYP])
          v = SCTC_V_UNDEF;
      end
      SCTC_K_MON_CFG:
      begin
        // RL17: secure aarch32 el1 traps to secure hyp
        if (c[`SCTC_B_SECHYP] && r[`SCTC_RQ_A32] && el == 2'd1 && r[`SCTC_RQ_SECURE])
        begin
          v = SCTC_V_TRAP_HYP;
          e = `SCTC_EC_CP15;
        end
      end
      SCTC_K_MON_BANK:
      begin
        // RL18: banked monitor access traps, class 0
        if (c[`SCTC_B_SECHYP] && r[`SCTC_RQ_A32] && el == 2'd1 && r[`SCTC_RQ_SECURE])
        begin
          v = SCTC_V_TRAP_HYP;
          e = `SCTC_EC_NONE;
        end
      end
      SCTC_K_SERROR:
      begin
        // RL11: routed serror taken at top unless masked and not nonmaskable
        // RL12: not routed means never taken at top
        if (c[`SCTC_B_EXT_ROUTE] && (nm || !r[`SCTC_RQ_AMASK]))
          v = SCTC_V_TRAP_TOP;
      end
      SCTC_K_AVOFF:
        // RL20: enabled bit leaves el2 access alone
        sys_trap = el == 2'd2 && !c[`SCTC_B_AVOFF];
      default:
      begin
        v = SCTC_V_ALLOW;
      end
    endcase
    // one place raises every system register trap, all with one class
    if (sys_trap)
    begin
      v = SCTC_V_TRAP_TOP;
      e = `SCTC_EC_SYSREG;
    end
    judge = {e, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus and config next state
  logic hit;   // valid new bus cycle
  assign hit = i_wb_cyc & i_wb_stb & ~ack;
  assign busy = (state == SCTC_S_WAIT);

  always_comb
  begin
    next_cfg = cfg;
    next_req = req;
    next_ack = hit;
    next_rdat = rdat;
    if (hit && i_wb_we)
    begin
      case (i_wb_adr)
        `SCTC_OFF_CFG_LO:
        begin
          for (int b = 0; b < 4; b++)
            if (i_wb_sel[b])
              next_cfg[b*8 +: 8] = i_wb_dat[b*8 +: 8] & CFG_MASK[b*8 +: 8];
        end
        `SCTC_OFF_CFG_HI:
        begin
          for (int b = 0; b < 4; b++)
            if (i_wb_sel[b])
              next_cfg[32 + b*8 +: 8] = i_wb_dat[b*8 +: 8] & CFG_MASK[32 + b*8 +: 8];
        end
        `SCTC_OFF_REQ:
        begin
          // a new check is ignored while one is in flight
          if (!busy && i_wb_sel[0] && i_wb_sel[1])
            next_req = i_wb_dat[10:0];
        end
        default:
        begin
          next_req = req;
        end
      endcase
    end
    if (hit && !i_wb_we)
    begin
      case (i_wb_adr)
        `SCTC_OFF_CFG_LO: next_rdat = cfg[31:0];
        `SCTC_OFF_CFG_HI: next_rdat = cfg[63:32];
        `SCTC_OFF_REQ: next_rdat = {21'h0, req};
        `SCTC_OFF_STAT: next_rdat = {24'h0, 3'h0, serr_vec, 1'b0, state == SCTC_S_DONE,
                                     verdict};
        `SCTC_OFF_EC: next_rdat = {26'h0, ec};
        default: next_rdat = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // check sequencer: wfe traps wait out the programmed delay
  logic go_new;  // request written with go bit
  assign go_new = hit && i_wb_we && i_wb_adr == `SCTC_OFF_REQ && !busy
                  && i_wb_sel[0] && i_wb_dat[`SCTC_RQ_GO];
  logic [7:0] jv;  // combined verdict of the held request
  assign jv = judge(req, cfg, fi_eff, nm_eff);

  always_comb
  begin
    next_state = state;
    next_dly_cnt = dly_cnt;
    next_verdict = verdict;
    next_ec = ec;
    next_serr_vec = serr_vec;
    case (state)
      SCTC_S_IDLE, SCTC_S_DONE:
      begin
        if (go_new)
        begin
          next_state = SCTC_S_WAIT;
          // RL3: enabled delay uses the programmed length
          next_dly_cnt = cfg[`SCTC_B_DLY_EN] ? dly_len : 24'd1;
        end
      end
      SCTC_S_WAIT:
      begin
        // only a trapping wfe waits; everything else resolves at once
        if (dly_cnt > 24'd1 && req[`SCTC_RQ_KIND_HI:0] == SCTC_K_WFE
            && jv[1:0] == SCTC_V_TRAP_TOP)
          next_dly_cnt = dly_cnt - 24'd1;
        else
        begin
          next_state = SCTC_S_DONE;
          next_verdict = jv[1:0];
          next_ec = jv[7:2];
          // RL14: sync abort vector choice
          next_serr_vec = (req[3:0] == SCTC_K_SYNC_ABORT) && cfg[`SCTC_B_SYNC_SERR];
        end
      end
      default:
      begin
        next_state = SCTC_S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // RL13: nonmaskable and sync vector bits clear
      // RL19: other fields unknown; zero chosen here
      cfg <= 64'h0000_0000_0000_0000;
      req <= 11'h000;
      verdict <= 2'h0;
      ec <= 6'h00;
      serr_vec <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
      state <= SCTC_S_IDLE;
      dly_cnt <= 24'h00_0000;
    end
    else
    begin
      cfg <= next_cfg;
      req <= next_req;
      verdict <= next_verdict;
      ec <= next_ec;
      serr_vec <= next_serr_vec;
      ack <= next_ack;
      rdat <= next_rdat;
      state <= next_state;
      dly_cnt <= next_dly_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_wb_ack = ack;
  assign o_wb_dat = rdat;
  // RL16: secure world under secure hyp runs aarch64 below
  assign o_lower_state_a64 = cfg[`SCTC_B_SECHYP] & req[`SCTC_RQ_SECURE];
  // RL15: secure hyp timers off when disabled
  assign o_sechyp_timers_en = cfg[`SCTC_B_SECHYP];
  // RL4: offset reads as zero when disabled
  assign o_phys_offset_zero = ~cfg[`SCTC_B_PHYSOFF];
  // RL7: context numbers read as zero when disabled
  assign o_ctxnum_zero = ~cfg[`SCTC_B_CTXNUM];
  // RL6: tag access blocked when disabled
  assign o_tag_access_ok = cfg[`SCTC_B_TAG];
  // RL5: el2 fine traps disabled when off
  assign o_fine_traps_live = cfg[`SCTC_B_FINE];

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_wfe_go;
    state != SCTC_S_WAIT && go_new && i_wb_dat[3:0] == SCTC_K_WFE;
  endsequence
  property p_ack_one;
    @(posedge i_mclk) disable iff (i_sys_rst) o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");
  property p_txmem;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (state == SCTC_S_WAIT && req[3:0] == SCTC_K_TXMEM && req[5:4] != 2'd3
       && !cfg[`SCTC_B_TXMEM]) |=> verdict == SCTC_V_UNDEF;
  endproperty
  a_txmem: assert property (p_txmem) else $error("txmem not undefined"); // RL1
  property p_wfe_ec;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (state == SCTC_S_DONE && verdict == SCTC_V_TRAP_TOP && req[3:0] == SCTC_K_WFE)
      |-> ec == `SCTC_EC_WFE;
  endproperty
  a_wfe_ec: assert property (p_wfe_ec) else $error("wfe class wrong"); // RL21
  property p_wfe_dly;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (s_wfe_go ##1 (cfg[`SCTC_B_DLY_EN] && cfg[`SCTC_B_WFE_TRAP] && req[5:4] != 2'd3))
      |-> (state == SCTC_S_WAIT) [*8];
  endproperty
  a_wfe_dly: assert property (p_wfe_dly) else $error("wfe trap too early"); // RL3
  property p_nm_unrouted;
    @(posedge i_mclk) disable iff (i_sys_rst) !cfg[`SCTC_B_EXT_ROUTE] |-> !nm_eff;
  endproperty
  a_nm_unrouted: assert property (p_nm_unrouted) else $error("nm not zero"); // RL12
  property p_fine;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (state == SCTC_S_WAIT && req[3:0] == SCTC_K_FINE && req[5:4] == 2'd2
       && !cfg[`SCTC_B_FINE]) |=> ec == `SCTC_EC_SYSREG && verdict == SCTC_V_TRAP_TOP;
  endproperty
  a_fine: assert property (p_fine) else $error("fine trap wrong"); // RL5
  property p_mon;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (state == SCTC_S_WAIT && req[3:0] == SCTC_K_MON_CFG && cfg[`SCTC_B_SECHYP]
       && req[6] && req[8] && req[5:4] == 2'd1) |=> ec == `SCTC_EC_CP15;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor trap class"); // RL17
  property p_timers;
    @(posedge i_mclk) disable iff (i_sys_rst)
      !cfg[`SCTC_B_SECHYP] |-> !o_sechyp_timers_en && !o_lower_state_a64;
  endproperty
  a_timers: assert property (p_timers) else $error("secure hyp leaks"); // RL15
endmodule : sctc_trap_ctrl
`default_nettype wire

/* shared/sctc_cfg.svh */
// sctc_cfg.svh: offsets, field positions and constants of the trap-control block
// assumes it is included by bare name from the package and from the design file
`ifndef SCTC_CFG_SVH
`define SCTC_CFG_SVH
// register byte offsets on the wishbone bus
`define SCTC_OFF_CFG_LO 8'h00
`define SCTC_OFF_CFG_HI 8'h04
`define SCTC_OFF_REQ 8'h08
`define SCTC_OFF_STAT 8'h0C
`define SCTC_OFF_EC 8'h10
// field positions inside the 64-bit security config
`define SCTC_B_WFE_TRAP 13
`define SCTC_B_SECHYP 18
`define SCTC_B_SYNC_SERR 19
`define SCTC_B_NMSERR 20
`define SCTC_B_FAULTINJ 21
`define SCTC_B_CTXNUM 25
`define SCTC_B_TAG 26
`define SCTC_B_FINE 27
`define SCTC_B_PHYSOFF 28
`define SCTC_B_DLY_EN 29
`define SCTC_B_DLY_LO 30
`define SCTC_B_DLY_HI 33
`define SCTC_B_TXMEM 34
`define SCTC_B_AVOFF 35
// external abort route bit: its place beside the block's fields is our own choice
`define SCTC_B_EXT_ROUTE 17
// writable mask of bits kept by this block: 35:25, 21:17 and 13
`define SCTC_CFG_MASK 64'h0000_000F_FE3E_2000
// exponent bias of the wfe delay
`define SCTC_DLY_BIAS 5'h08
// exception class codes
`define SCTC_EC_NONE 6'h00
`define SCTC_EC_WFE 6'h01
`define SCTC_EC_CP15 6'h03
`define SCTC_EC_SYSREG 6'h18
// request register fields
`define SCTC_RQ_KIND_LO 0
`define SCTC_RQ_KIND_HI 3
`define SCTC_RQ_EL_LO 4
`define SCTC_RQ_EL_HI 5
`define SCTC_RQ_A32 6
`define SCTC_RQ_GO 7
`define SCTC_RQ_SECURE 8
`define SCTC_RQ_AMASK 9
`define SCTC_RQ_LOWER 10
`endif

/* shared/sctc_pkg.sv */
// sctc_pkg.sv: types of the trap-control block
// assumes sctc_cfg.svh is on the include path
`include "sctc_cfg.svh"
package sctc_pkg;
  // kinds of access that a lower level may attempt
  typedef enum logic [3:0] {
    SCTC_K_NONE, SCTC_K_TXMEM, SCTC_K_WFE, SCTC_K_PHYSOFF, SCTC_K_FINE,
    SCTC_K_TAG, SCTC_K_CTXNUM, SCTC_K_FAULTINJ, SCTC_K_SECHYP_REG,
    SCTC_K_MON_CFG, SCTC_K_MON_BANK, SCTC_K_SERROR, SCTC_K_SYNC_ABORT,
    SCTC_K_AVOFF
  } sctc_kind_e;
  // verdict on a checked access
  typedef enum logic [1:0] {
    SCTC_V_ALLOW, SCTC_V_UNDEF, SCTC_V_TRAP_TOP, SCTC_V_TRAP_HYP
  } sctc_verdict_e;
  // wfe delay sequencer states
  typedef enum logic [1:0] {
    SCTC_S_IDLE, SCTC_S_WAIT, SCTC_S_DONE
  } sctc_state_e;
endpackage : sctc_pkg

/* verification/sctc_trap_ctrl_tb.sv */
// sctc_trap_ctrl_tb.sv: self-checking bench for the trap-control block
// assumes sctc_pkg and sctc_cfg.svh are compiled and on the include path
`timescale 1ns/10ps
`default_nettype none
`include "sctc_cfg.svh"
module sctc_trap_ctrl_tb
  import sctc_pkg::*;
;
  // clock, reset and wishbone drive
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  // design outputs
  logic [31:0] rdat;
  logic ack, a64, timers_en, physoff_zero, ctx_zero, tag_ok, fine_live;
  // tallies
  int fails = 0;
  int n_tests = 0;

  ////////////////////////////////////////////////////////////////////////////
  // device under test
  sctc_trap_ctrl dut
  (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_lower_state_a64(a64),
    .o_sechyp_timers_en(timers_en), .o_phys_offset_zero(physoff_zero),
    .o_ctxnum_zero(ctx_zero), .o_tag_access_ok(tag_ok), .o_fine_traps_live(fine_live)
  );

  // 250 MHz clock
  always #2 i_mclk = ~i_mclk;

  ////////////////////////////////////////////////////////////////////////////
  // closing report, the one exit of the run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // compare seen against expected, count both outcomes
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high at a rising edge
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge i_mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      fails++;
      end_sim();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // write helper
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] junk;
    wb_cycle(1'b1, a, d, junk);
  endtask

  // load cfg, launch a check, poll done; returns status, class and cycles
  task automatic run_chk(input logic [31:0] hi, input logic [31:0] lo,
                         input logic [10:0] rq, output logic [31:0] st,
                         output logic [31:0] ec, output int cyc_n);
    int n;
    realtime t0;
    wr(`SCTC_OFF_CFG_LO, lo);
    wr(`SCTC_OFF_CFG_HI, hi);
    wr(`SCTC_OFF_REQ, {21'h0, rq | 11'h080});
    t0 = $realtime;
    n = 0;
    do
    begin
      wb_cycle(1'b0, `SCTC_OFF_STAT, 32'h0000_0000, st);
      n++;
    end
    while (st[2] !== 1'b1 && n < 800);
    if (n >= 800)
    begin
      fails++;
      end_sim();
    end
    cyc_n = int'(($realtime - t0) / 4.0);
    wb_cycle(1'b0, `SCTC_OFF_EC, 32'h0000_0000, ec);
  endtask

  // one check: verdict always, class when exp_ec bit 7 is clear
  task automatic vcheck(input logic [31:0] hi, input logic [31:0] lo, input logic [10:0] rq,
                        input logic [1:0] v, input logic [7:0] exp_ec);
    logic [31:0] st, ec;
    int c;
    run_chk(hi, lo, rq, st, ec, c);
    check({30'h0, st[1:0]}, {30'h0, v});
    if (!exp_ec[7])
      check({26'h0, ec[5:0]}, {26'h0, exp_ec[5:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [31:0] r;
    // zero-value flags high, all enables low
    check({26'h0, a64, timers_en, physoff_zero, ctx_zero, tag_ok, fine_live},
          32'h0000_000C);
    wb_cycle(1'b0, `SCTC_OFF_CFG_LO, 32'h0000_0000, r);
    // nonmaskable and sync-vector bits clear
    check(r & 32'h0018_0000, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [31:0] r;
    wr(`SCTC_OFF_CFG_LO, 32'hFFFF_FFFF);
    wr(`SCTC_OFF_CFG_HI, 32'hFFFF_FFFF);
    wb_cycle(1'b0, `SCTC_OFF_CFG_LO, 32'h0000_0000, r);
    check(r, 32'hFE3E_2000);
    wb_cycle(1'b0, `SCTC_OFF_CFG_HI, 32'h0000_0000, r);
    check(r, 32'h0000_000F);
    // level outputs follow the enables
    check({28'h0, physoff_zero, ctx_zero, tag_ok, fine_live}, 32'h0000_0003);
    check({31'h0, timers_en}, 32'h0000_0001);
    // unmapped place reads zero and drops writes
    wr(8'h40, 32'hA5A5_A5A5);
    wb_cycle(1'b0, 8'h40, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    wr(`SCTC_OFF_CFG_LO, 32'h0000_0000);
    check({31'h0, timers_en}, 32'h0000_0000);
    check({30'h0, physoff_zero, ctx_zero}, 32'h0000_0003);
    $display("test regs done");
  endtask

  // request fields: lower[10] amask[9] secure[8] go[7] a32[6] el[5:4] kind[3:0]
  task automatic t_traps();
    vcheck(32'h0, 32'h0, 11'h011, SCTC_V_UNDEF, 8'h80);
    vcheck(32'h4, 32'h0, 11'h011, SCTC_V_ALLOW, 8'h80);
    vcheck(32'h0, 32'h0, 11'h023, SCTC_V_TRAP_TOP, 8'h80);
    vcheck(32'h0, 32'h1000_0000, 11'h023, SCTC_V_ALLOW, 8'h80);
    vcheck(32'h0, 32'h0, 11'h024, SCTC_V_TRAP_TOP, 8'h18);
    vcheck(32'h0, 32'h0, 11'h015, SCTC_V_TRAP_TOP, 8'h80);
    vcheck(32'h0, 32'h0400_0000, 11'h015, SCTC_V_ALLOW, 8'h80);
    vcheck(32'h0, 32'h0, 11'h006, SCTC_V_TRAP_TOP, 8'h80);
    vcheck(32'h0, 32'h0, 11'h017, SCTC_V_TRAP_TOP, 8'h18);
    vcheck(32'h0, 32'h0020_0000, 11'h027, SCTC_V_ALLOW, 8'h80);
    vcheck(32'h0, 32'h0, 11'h108, SCTC_V_UNDEF, 8'h80);
    vcheck(32'h8, 32'h0, 11'h02D, SCTC_V_ALLOW, 8'h80);
    $display("test traps done");
  endtask

  task automatic t_sechyp();
    // secure aarch32 el1 with secure hyp enabled
    vcheck(32'h0, 32'h0004_0000, 11'h159, SCTC_V_TRAP_HYP, 8'h03);
    vcheck(32'h0, 32'h0004_0000, 11'h15A, SCTC_V_TRAP_HYP, 8'h00);
    // secure world seen: lower state reads aarch64
    check({31'h0, a64}, 32'h0000_0001);
    // non-secure aarch32 el1: no trap, lower state not forced
    vcheck(32'h0, 32'h0004_0000, 11'h059, SCTC_V_ALLOW, 8'h80);
    check({31'h0, a64}, 32'h0000_0000);
    $display("test sechyp done");
  endtask

  task automatic t_abort();
    logic [31:0] st, ec;
    int c;
    run_chk(32'h0, 32'h0008_0000, 11'h01C, st, ec, c);
    check({31'h0, st[4]}, 32'h0000_0001);
    run_chk(32'h0, 32'h0, 11'h01C, st, ec, c);
    check({31'h0, st[4]}, 32'h0000_0000);
    // unrouted serror with nonmaskable set, mask set then clear: never taken at top
    run_chk(32'h0, 32'h0010_0000, 11'h21B, st, ec, c);
    check({31'h0, st[1:0] == SCTC_V_TRAP_TOP}, 32'h0000_0000);
    run_chk(32'h0, 32'h0010_0000, 11'h01B, st, ec, c);
    check({31'h0, st[1:0] == SCTC_V_TRAP_TOP}, 32'h0000_0000);
    // routed: nonmaskable ignores the mask, plain bit obeys it
    run_chk(32'h0, 32'h0012_0000, 11'h21B, st, ec, c);
    check({31'h0, st[1:0] == SCTC_V_TRAP_TOP}, 32'h0000_0001);
    run_chk(32'h0, 32'h0002_0000, 11'h21B, st, ec, c);
    check({31'h0, st[1:0] == SCTC_V_TRAP_TOP}, 32'h0000_0000);
    // mid-run warm reset clears both abort bits again
    wr(`SCTC_OFF_CFG_LO, 32'h0018_0000);
    wb_cycle(1'b0, `SCTC_OFF_CFG_LO, 32'h0000_0000, st);
    check(st & 32'h0018_0000, 32'h0018_0000);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    wb_cycle(1'b0, `SCTC_OFF_CFG_LO, 32'h0000_0000, st);
    check(st & 32'h0018_0000, 32'h0000_0000);
    $display("test abort done");
  endtask

  task automatic t_wfe();
    logic [31:0] st, ec;
    int c;
    vcheck(32'h0, 32'h0000_2000, 11'h012, SCTC_V_TRAP_TOP, 8'h01);
    vcheck(32'h0, 32'h0, 11'h012, SCTC_V_ALLOW, 8'h80);
    // exponent 0 and 1 with delay enabled: at least 256 and 512 cycles
    run_chk(32'h0, 32'h2000_2000, 11'h012, st, ec, c);
    check({31'h0, c >= 256}, 32'h0000_0001);
    check({26'h0, ec[5:0]}, 32'h0000_0001);
    run_chk(32'h0, 32'h6000_2000, 11'h022, st, ec, c);
    check({31'h0, c >= 512}, 32'h0000_0001);
    check({30'h0, st[1:0]}, {30'h0, SCTC_V_TRAP_TOP});
    $display("test wfe done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    t_reset();
    t_regs();
    t_traps();
    t_sechyp();
    t_abort();
    t_wfe();
    end_sim();
  end
endmodule // sctc_trap_ctrl_tb
`default_nettype wire
